// ===== rtl/tone_generator.sv
// Square-wave tone generator with divider and control registers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tone_generator (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [tone_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tone_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [tone_pkg::DATA_W-1:0] reg_rdata_o,
  output logic tone_output_pin_o
);
  import tone_pkg::*;

  reg_req_s req;
  tone_cfg_s cfg;
  logic [DATA_W-1:0] tone_divider_q;
  logic [DATA_W-1:0] tone_divider_d;
  logic [DATA_W-1:0] tone_control_q;
  logic [DATA_W-1:0] tone_control_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] count_d;
  logic wave_q;
  logic wave_d;
  logic tick;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  assign cfg = '{clock_select: tone_control_q[TONE_CLOCK_SELECT_LSB +: TONE_CLOCK_SELECT_W],
                 enable: tone_control_q[TONE_ENABLE_BIT]};

  // Register file; unused control bits read as zero, unmapped reads return zero
  always_comb begin
    tone_divider_d = tone_divider_q;
    tone_control_d = tone_control_q;
    rdata_d = '0;
    if (req.wr) begin
      if (req.addr == TONE_DIVIDER_OFFSET) begin
        tone_divider_d = req.wdata; // R4
      end else if (req.addr == TONE_CONTROL_OFFSET) begin
        tone_control_d = {5'h00, req.wdata[2:0]};
      end
    end
    if (req.rd) begin
      if (req.addr == TONE_DIVIDER_OFFSET) begin
        rdata_d = tone_divider_q;
      end else if (req.addr == TONE_CONTROL_OFFSET) begin
        rdata_d = tone_control_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_divider_q <= TONE_DIVIDER_RESET; // R6
      tone_control_q <= TONE_CONTROL_RESET; // R6
      rdata_q <= '0;
    end else begin
      tone_divider_q <= tone_divider_d;
      tone_control_q <= tone_control_d;
      rdata_q <= rdata_d;
    end
  end

  tone_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(cfg.enable),
    .select_i(cfg.clock_select),
    .tick_o(tick)
  );

  // Half period is (divider + 1) ticks, giving fx / (2 x ratio x (divider + 1))
  // A divider write mid-count takes effect at once; a count above the new value restarts
  always_comb begin
    count_d = count_q;
    wave_d = wave_q;
    if (!cfg.enable) begin
      count_d = '0; // R5
      wave_d = 1'b0; // R9
    end else if (tick) begin
      if (count_q >= tone_divider_q) begin
        count_d = '0; // R9
        wave_d = ~wave_q; // R2
      end else begin
        count_d = count_q + 8'h01; // R1
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      wave_q <= 1'b0;
    end else begin
      count_q <= count_d;
      wave_q <= wave_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign tone_output_pin_o = wave_q; // R7

endmodule : tone_generator
`default_nettype wire

// ===== rtl/tone_pkg.sv
// Constants, register map and carrier types of the square-wave tone generator
// Behaviour
// R1 - An 8-bit counter clocked by the selected prescaled tick produces the square wave on the tone output pin.
// R2 - Output frequency is main clock / (2 x prescaler ratio x (divider value + 1)).
// R3 - Clock select 00 gives main clock /32, 01 gives /64, 10 gives /128 and 11 gives /256.
// R4 - The 8-bit divider register accepts every value from 00 to FF, each setting the count length.
// R5 - With the enable bit (bit 0 of the control register) at 0 the generator is off and makes no square wave.
// R6 - After reset the divider reads FF and the control register reads 00.
// R7 - With the enable bit at 1 the counter runs and the square wave is driven onto the tone output pin.
// R8 - The prescaler reference is the main system clock.
// R9 - The counter counts ticks from zero up to the divider value, then restarts and toggles the output; disabled output is held low.
package tone_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] TONE_DIVIDER_OFFSET = 8'h8F;
  localparam logic [ADDR_W-1:0] TONE_CONTROL_OFFSET = 8'h9F;

  localparam logic [DATA_W-1:0] TONE_DIVIDER_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] TONE_CONTROL_RESET = 8'h00;

  localparam int unsigned TONE_ENABLE_BIT = 0;
  localparam int unsigned TONE_CLOCK_SELECT_LSB = 1;
  localparam int unsigned TONE_CLOCK_SELECT_W = 2;

  // Prescaler counts main clock cycles while enabled and is held at zero when off; /32 up to /256
  localparam int unsigned PRESCALE_W = 8;
  localparam int unsigned PRESCALE_LOG2_BASE = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [TONE_CLOCK_SELECT_W-1:0] clock_select;
    logic enable;
  } tone_cfg_s;

endpackage : tone_pkg

// ===== rtl/tone_prescaler.sv
// Main-clock prescaler producing the selected one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module tone_prescaler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [tone_pkg::TONE_CLOCK_SELECT_W-1:0] select_i,
  output logic tick_o
);
  import tone_pkg::*;

  logic [PRESCALE_W-1:0] count_q;
  logic [PRESCALE_W-1:0] count_d;
  logic tick_q;
  logic tick_d;
  logic [PRESCALE_W-1:0] last;

  always_comb begin
    // Terminal value is ratio - 1 for ratio 32 << select
    last = PRESCALE_W'((32'd1 << (PRESCALE_LOG2_BASE + 32'(select_i))) - 32'd1); // R3
    count_d = count_q;
    tick_d = 1'b0;
    if (!run_i) begin
      count_d = '0;
    end else if (count_q >= last) begin
      count_d = '0;
      tick_d = 1'b1; // R8
    end else begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : tone_prescaler
`default_nettype wire

// ===== tb/tone_properties.sv
// Port checker for the tone generator
`timescale 1ns/1ps
`default_nettype none
module tone_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic tone_output_pin_o
);
  logic [7:0] div_q;
  logic [2:0] ctl_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow copies so reads can be judged without the bodies
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 8'hFF;
      ctl_q <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h8F) begin
      div_q <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h9F) begin
      ctl_q <= reg_wdata_i[2:0];
    end
  end
  a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("rdata idle");
  a_read_div: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h8F |-> reg_rdata_o == div_q)
    else $error("divider read");
  a_read_ctl: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h9F |-> reg_rdata_o == {5'h00, ctl_q})
    else $error("control read");
  a_read_hole: assert property ($past(reg_rd_i) && !($past(reg_addr_i) inside {8'h8F, 8'h9F}) |-> reg_rdata_o == 8'h00)
    else $error("hole read");
  a_tone_off: assert property ((!ctl_q[0])[*3] |-> !tone_output_pin_o) else $error("tone while off");
  // The rise is launched from the enable seen one edge earlier, so a disable landing on that edge is legal
  a_rise_enabled: assert property ($rose(tone_output_pin_o) |-> $past(ctl_q[0])) else $error("rise while off");
  a_enable_quiet: assert property ($rose(ctl_q[0]) |-> (!tone_output_pin_o)[*8]) else $error("early tone");
  // Fastest half period is 32 clocks, so eight steady clocks is a safe floor
  a_tone_hold: assert property ($changed(tone_output_pin_o) |=> ($stable(tone_output_pin_o) || !ctl_q[0])[*8])
    else $error("tone too fast");
endmodule : tone_properties
`default_nettype wire

// ===== tb/tone_listener.sv
// Buzzer stand-in that times each half period of the tone pin
`timescale 1ns/1ps
`default_nettype none
module tone_listener (
  input wire logic clk_i,
  input wire logic tone_i,
  output int half_o,
  output int edges_o
);
  int run = 0;
  logic last = 1'b0;
  // A passive coil: it only listens, so it cannot disturb the pin
  always @(posedge clk_i) begin
    run++;
    if (tone_i !== last) begin
      half_o = run;
      edges_o++;
      run = 0;
      last = tone_i;
    end
  end
endmodule : tone_listener
`default_nettype wire

// ===== tb/tone_generator_tb.sv
// Self-checking bench for the tone generator
`timescale 1ns/1ps
`default_nettype none
module tone_generator_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, tone_output_pin_o;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  int num_errors = 0, samples_checked = 0, seed = 32'ha783fbd6, div_m = 255, ctl_m = 0, e, half, edges;
  always #10 clk_i = ~clk_i;
  tone_generator i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tone_output_pin_o(tone_output_pin_o));
  tone_listener i_buzzer (.clk_i(clk_i), .tone_i(tone_output_pin_o), .half_o(half), .edges_o(edges));
  task automatic chk(input string n, input logic [31:0] x, s);
    samples_checked++;
    if (s !== x) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    if (a == 8'h8F) div_m = d;
    if (a == 8'h9F) ctl_m = d & 7;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", a == 8'h8F ? div_m : a == 8'h9F ? ctl_m : 0, {24'h0, reg_rdata_o});
  endtask : rd
  task automatic results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    #1000000;
    num_errors++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h8F);
    rd(8'h9F);
    rd(8'h55);
    wr(8'h9F, 8'hF8);
    rd(8'h9F);
    repeat (40) @(posedge clk_i);
    chk("tone", 0, tone_output_pin_o);
    // Last pass uses the longest count to reach the top of the divider range
    for (int s = 0; s < 5; s++) begin
      wr(8'h8F, s == 4 ? 8'hFF : 8'($random(seed)) & 8'h03);
      wr(8'h9F, {5'h00, 2'(s), 1'b1});
      rd(8'h8F);
      e = edges;
      for (int k = 0; k < 30000 && edges < e + 3; k++) @(posedge clk_i);
      chk("half", (32 << (ctl_m >> 1)) * (div_m + 1), half);
      wr(8'h9F, 8'h00);
      repeat (3) @(posedge clk_i);
      chk("off", 0, tone_output_pin_o);
    end
    results;
  end
endmodule : tone_generator_tb
bind tone_generator tone_properties i_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .tone_output_pin_o(tone_output_pin_o));
`default_nettype wire
